// ---- inc/raster_irq_pkg.sv ----
/*
  Register map, bit positions and sizes for the raster, blanking and interrupt
  block. Assumes a byte-wide processor port with a 16-bit address.
*/
package raster_irq_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int LINE_W = 9;

  // ==========================================================
  // register offsets
  localparam logic [15:0] DISPLAY_CONTROL_ADDR = 16'hd011;
  localparam logic [15:0] RASTER_LINE_ADDR     = 16'hd012;
  localparam logic [15:0] IRQ_STATUS_ADDR      = 16'hd019;
  localparam logic [15:0] IRQ_ENABLE_ADDR      = 16'hd01a;

  // ==========================================================
  // field positions
  localparam int CTRL_LINE_MSB_BIT = 7;
  localparam int CTRL_SHOW_BIT     = 4;
  localparam int RASTER_MATCH_BIT  = 0;
  localparam int SPR_BG_BIT        = 1;
  localparam int SPR_SPR_BIT       = 2;
  localparam int LIGHT_PEN_BIT     = 3;
  localparam int IRQ_ANY_BIT       = 7;
  localparam int SOURCE_CNT        = 4;

  // ==========================================================
  // reset values (none documented; display shown, all sources off)
  localparam logic [7:0] CTRL_RESET   = 8'h10;
  localparam logic [8:0] TARGET_RESET = 9'h000;
  localparam logic [3:0] FLAGS_RESET  = 4'h0;
  localparam logic [7:0] UNUSED_READ  = 8'hff;

  // ==========================================================
  // frame geometry
  localparam int LINES_PER_FRAME = 312;
  localparam int CYCLES_PER_LINE = 63;

endpackage : raster_irq_pkg

// ---- rtl/raster_irq_and_blanking.sv ----
/*
  Display blanking, raster line counter with compare, and latched interrupt
  status/enable with one interrupt request output.
  Assumes a synchronous byte-wide host port on the same clock; collision and
  light pen inputs come from outside and are synchronised here.
  Collision inputs are taken as levels: one held high keeps its flag set
  through a clear, so the source must drop before software acknowledges.
  The light pen pin idles high; only a fall counts, and only once per frame.
*/
`timescale 1ns/10ps
`default_nettype none

module raster_irq_and_blanking #(
  parameter int LINES  = raster_irq_pkg::LINES_PER_FRAME,
  parameter int CYCLES = raster_irq_pkg::CYCLES_PER_LINE
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        busSelect,
  input  wire logic        busWrite,
  input  wire logic [15:0] busAddr,
  input  wire logic [7:0]  busWriteData,
  output logic      [7:0]  busReadData,
  input  wire logic        spriteBackgroundHit,
  input  wire logic        spriteSpriteHit,
  input  wire logic        lightPenIn,
  input  wire logic        badLineRequest,
  output logic             displayEnable,
  output logic             busStealRequest,
  output logic             irqRequest,
  output logic [8:0]       rasterLine
);

  // ==========================================================
  // input synchronisers, one two-stage chain per pin
  localparam int         SYNC_CNT  = 3;
  localparam int         PEN_SYNC  = 2;
  // chains reset to idle pin levels: a low pen chain would fake a fall
  localparam logic [2:0] SYNC_IDLE = 3'h4;

  logic [SYNC_CNT-1:0] pinRaw;
  logic [SYNC_CNT-1:0] syncA_ff;
  logic [SYNC_CNT-1:0] syncB_ff;
  logic                penPrev_ff;
  logic                sbHitS;
  logic                ssHitS;
  logic                penS;

  assign pinRaw = {lightPenIn, spriteSpriteHit, spriteBackgroundHit};

  genvar gs;
  generate
    for (gs = 0; gs < SYNC_CNT; gs++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          syncA_ff[gs] <= SYNC_IDLE[gs];
          syncB_ff[gs] <= SYNC_IDLE[gs];
        end else begin
          syncA_ff[gs] <= pinRaw[gs];
          syncB_ff[gs] <= syncA_ff[gs];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      penPrev_ff <= SYNC_IDLE[PEN_SYNC];
    end else begin
      penPrev_ff <= syncB_ff[PEN_SYNC];
    end
  end

  assign sbHitS = syncB_ff[0];
  assign ssHitS = syncB_ff[1];
  assign penS   = syncB_ff[PEN_SYNC];

  // ==========================================================
  // raster position
  logic [6:0] dotCnt_ff;
  logic [6:0] nxt_dotCnt;
  logic [8:0] line_ff;
  logic [8:0] nxt_line;
  logic       lineStart;
  logic       frameStart;

  always_comb begin
    nxt_dotCnt = dotCnt_ff + 7'h01;
    nxt_line   = line_ff;
    lineStart  = 1'b0;
    frameStart = 1'b0;
    if (dotCnt_ff == 7'(CYCLES - 1)) begin
      nxt_dotCnt = 7'h00;
      lineStart  = 1'b1;
      if (line_ff == 9'(LINES - 1)) begin
        nxt_line   = 9'h000;
        frameStart = 1'b1;
      end else begin
        nxt_line = line_ff + 9'h001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dotCnt_ff <= 7'h00;
      line_ff   <= 9'h000;
    end else begin
      dotCnt_ff <= nxt_dotCnt;
      line_ff   <= nxt_line;
    end
  end

  assign rasterLine = line_ff;

  // ==========================================================
  // registers and interrupt latches
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [8:0] target_ff;
  logic [8:0] nxt_target;
  logic [3:0] flags_ff;
  logic [3:0] nxt_flags;
  logic [3:0] enable_ff;
  logic [3:0] nxt_enable;
  logic       penDone_ff;
  logic       nxt_penDone;
  logic       penEvent;
  logic       matchPrev_ff;
  logic       lineMatch;
  logic [3:0] events;
  logic [3:0] clearMask;
  logic       wrCtrl;
  logic       wrLine;
  logic       wrStatus;
  logic       wrEnable;

  assign wrCtrl   = busSelect && busWrite && busAddr == raster_irq_pkg::DISPLAY_CONTROL_ADDR;
  assign wrLine   = busSelect && busWrite && busAddr == raster_irq_pkg::RASTER_LINE_ADDR;
  assign wrStatus = busSelect && busWrite && busAddr == raster_irq_pkg::IRQ_STATUS_ADDR;
  assign wrEnable = busSelect && busWrite && busAddr == raster_irq_pkg::IRQ_ENABLE_ADDR;

  assign lineMatch = (line_ff == target_ff);

  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_target = target_ff;
    clearMask  = 4'h0;
    // writes load target, never live count
    if (wrCtrl) begin
      nxt_ctrl = busWriteData;
      nxt_target[8] = busWriteData[raster_irq_pkg::CTRL_LINE_MSB_BIT];
    end
    if (wrLine) begin
      nxt_target[7:0] = busWriteData;
    end
    if (wrStatus) begin
      clearMask = busWriteData[3:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_ff      <= raster_irq_pkg::CTRL_RESET;
      target_ff    <= raster_irq_pkg::TARGET_RESET;
      matchPrev_ff <= 1'b0;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      target_ff    <= nxt_target;
      matchPrev_ff <= lineMatch;
    end
  end

  // ==========================================================
  // light pen arming
  // a fall on the frame's last cycle still counts, charged to the new frame
  // falling edge, once per frame
  always_comb begin
    nxt_penDone = penDone_ff;
    penEvent    = 1'b0;
    if (frameStart) begin
      nxt_penDone = 1'b0;
    end
    if (penPrev_ff && !penS && (!penDone_ff || frameStart)) begin
      penEvent    = 1'b1;
      nxt_penDone = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      penDone_ff <= 1'b0;
    end else begin
      penDone_ff <= nxt_penDone;
    end
  end

  // ==========================================================
  // event sources
  always_comb begin
    events = 4'h0;
    events[raster_irq_pkg::RASTER_MATCH_BIT] = lineMatch && !matchPrev_ff;
    events[raster_irq_pkg::SPR_BG_BIT] = sbHitS;
    events[raster_irq_pkg::SPR_SPR_BIT] = ssHitS;
    events[raster_irq_pkg::LIGHT_PEN_BIT] = penEvent;
  end

  // ==========================================================
  // per-source latches and enables
  // a set arriving with its clear wins, so no event is ever lost
  genvar gf;
  generate
    for (gf = 0; gf < raster_irq_pkg::SOURCE_CNT; gf++) begin : g_flag
      always_comb begin
        nxt_flags[gf]  = flags_ff[gf];
        nxt_enable[gf] = enable_ff[gf];
        if (clearMask[gf]) begin
          nxt_flags[gf] = 1'b0;
        end
        if (events[gf]) begin
          nxt_flags[gf] = 1'b1;
        end
        if (wrEnable) begin
          nxt_enable[gf] = busWriteData[gf];
        end
      end

      always_ff @(posedge clock) begin
        if (!reset_n) begin
          flags_ff[gf]  <= raster_irq_pkg::FLAGS_RESET[gf];
          enable_ff[gf] <= raster_irq_pkg::FLAGS_RESET[gf];
        end else begin
          flags_ff[gf]  <= nxt_flags[gf];
          enable_ff[gf] <= nxt_enable[gf];
        end
      end
    end
  endgenerate

  // ==========================================================
  // outputs
  logic       irqAny;
  logic [7:0] nxt_readData;

  assign irqAny = |(flags_ff & enable_ff);

  assign irqRequest = irqAny;

  assign displayEnable = ctrl_ff[raster_irq_pkg::CTRL_SHOW_BIT];

  // no display fetch stealing while blanked
  assign busStealRequest = badLineRequest && ctrl_ff[raster_irq_pkg::CTRL_SHOW_BIT];

  // read data holds until the next read, so a slow host may sample late
  always_comb begin
    nxt_readData = busReadData;
    if (busSelect && !busWrite) begin
      case (busAddr)
        // live top bit in bit 7
        raster_irq_pkg::DISPLAY_CONTROL_ADDR: nxt_readData = {line_ff[8], ctrl_ff[6:0]};
        raster_irq_pkg::RASTER_LINE_ADDR:     nxt_readData = line_ff[7:0];
        // summary bit 7, unused bits read one
        raster_irq_pkg::IRQ_STATUS_ADDR:      nxt_readData = {irqAny, 3'h7, flags_ff};
        raster_irq_pkg::IRQ_ENABLE_ADDR:      nxt_readData = {4'hf, enable_ff};
        default:                              nxt_readData = raster_irq_pkg::UNUSED_READ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      busReadData <= 8'h00;
    end else begin
      busReadData <= nxt_readData;
    end
  end

endmodule : raster_irq_and_blanking

`default_nettype wire

// ---- dv/raster_irq_monitor.sv ----
/* port checker for the raster, blanking and interrupt block.
   bound to every instance below; one clock, sync active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module raster_irq_monitor #(
  parameter int LINES  = 312,
  parameter int CYCLES = 63
) (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        busSelect,
  input wire logic        busWrite,
  input wire logic [15:0] busAddr,
  input wire logic [7:0]  busWriteData,
  input wire logic [7:0]  busReadData,
  input wire logic        badLineRequest,
  input wire logic        displayEnable,
  input wire logic        busStealRequest,
  input wire logic        irqRequest,
  input wire logic [8:0]  rasterLine
);
  logic rd;
  logic wr;
  assign rd = busSelect && !busWrite;
  assign wr = busSelect && busWrite;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // assertions
  property p_blank;
    wr && busAddr == 16'hd011 |=> displayEnable == $past(busWriteData[4]); endproperty
  a_blank: assert property (p_blank) else $error("blanking bit not obeyed");
  property p_steal; busStealRequest == (badLineRequest && displayEnable); endproperty
  a_steal: assert property (p_steal) else $error("bus steal while blanked");
  property p_lineRd; rd && busAddr == 16'hd012 |=> busReadData == $past(rasterLine[7:0]);
  endproperty
  a_lineRd: assert property (p_lineRd) else $error("line low byte wrong");
  property p_msbRd; rd && busAddr == 16'hd011 |=> busReadData[7] == $past(rasterLine[8]);
  endproperty
  a_msbRd: assert property (p_msbRd) else $error("line top bit wrong");
  // writes never disturb the live count: it only steps or wraps
  property p_line; $changed(rasterLine) |-> rasterLine ==
    ($past(rasterLine) == 9'(LINES - 1) ? 9'h000 : $past(rasterLine) + 9'h001); endproperty
  a_line: assert property (p_line) else $error("line count jumped");
  property p_irqRd; rd && busAddr == 16'hd019 |=> busReadData[7] == $past(irqRequest);
  endproperty
  a_irqRd: assert property (p_irqRd) else $error("status bit 7 wrong");
  property p_enRd; wr && busAddr == 16'hd01a ##3 rd && busAddr == 16'hd01a
    |=> busReadData[3:0] == $past(busWriteData[3:0], 4); endproperty
  a_enRd: assert property (p_enRd) else $error("enable readback wrong");
  property p_irqOff; wr && busAddr == 16'hd01a && busWriteData[3:0] == 4'h0 |=> !irqRequest;
  endproperty
  a_irqOff: assert property (p_irqOff) else $error("request while disabled");
  c_irq: cover property ($rose(irqRequest));
  c_wrap: cover property (rasterLine == 9'h000 && $past(rasterLine) != 9'h000);
  c_blank: cover property ($fell(displayEnable));
endmodule : raster_irq_monitor
bind raster_irq_and_blanking raster_irq_monitor #(.LINES(LINES), .CYCLES(CYCLES)) u_mon (
  .clock(clock), .reset_n(reset_n), .busSelect(busSelect), .busWrite(busWrite),
  .busAddr(busAddr), .busWriteData(busWriteData), .busReadData(busReadData),
  .badLineRequest(badLineRequest), .displayEnable(displayEnable),
  .busStealRequest(busStealRequest), .irqRequest(irqRequest), .rasterLine(rasterLine));
`default_nettype wire

// ---- dv/host_bus_model.sv ----
/* host processor model: one byte access per call, plus handler helpers.
   assumes the block takes a request on the edge after it is driven. */
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  input  wire logic        clock,
  output logic             busSelect,
  output logic             busWrite,
  output logic [15:0]      busAddr,
  output logic [7:0]       busWriteData,
  input  wire logic [7:0]  busReadData
);
  initial begin
    busSelect = 1'b0;
    busWrite = 1'b0;
    busAddr = 16'h0000;
    busWriteData = 8'h00;
  end
  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clock);
    busSelect <= 1'b1;
    busWrite <= w;
    busAddr <= a;
    busWriteData <= d;
    @(posedge clock);
    // released address and data lines show the inverse, never a stale copy
    busSelect <= 1'b0;
    busAddr <= ~a;
    busWriteData <= ~d;
    @(posedge clock);
    q = busReadData;
  endtask : access
  task automatic ack(input logic [7:0] m);
    logic [7:0] q;
    access(1'b1, 16'hd019, m, q);
  endtask : ack
  task automatic raster_handler(input logic [7:0] ctrl, input logic [8:0] target);
    logic [7:0] q;
    access(1'b1, 16'hd011, {target[8], ctrl[6:0]}, q);
    access(1'b1, 16'hd012, target[7:0], q);
  endtask : raster_handler
endmodule : host_bus_model
`default_nettype wire

// ---- dv/tb_raster_irq_and_blanking.sv ----
/* self-checking bench for the raster, blanking and interrupt block.
   assumes a short frame of 8 lines of 4 clocks. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin nTests++; if ((g) !== (e)) begin nFail++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_raster_irq_and_blanking;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        busSelect;
  logic        busWrite;
  logic [15:0] busAddr;
  logic [7:0]  busWriteData;
  logic [7:0]  busReadData;
  logic        bgHit = 1'b0;
  logic        sprHit = 1'b0;
  logic        pen = 1'b1;
  logic        badLine = 1'b1;
  logic        displayEnable;
  logic        busStealRequest;
  logic        irqRequest;
  logic [8:0]  rasterLine;
  logic [7:0]  q;
  int          nFail = 0;
  int          nTests = 0;
  always #5 clock = ~clock;
  host_bus_model host (.clock(clock), .busSelect(busSelect), .busWrite(busWrite),
    .busAddr(busAddr), .busWriteData(busWriteData), .busReadData(busReadData));
  raster_irq_and_blanking #(.LINES(8), .CYCLES(4)) u_raster_irq_and_blanking (
    .clock(clock), .reset_n(reset_n), .busSelect(busSelect), .busWrite(busWrite),
    .busAddr(busAddr), .busWriteData(busWriteData), .busReadData(busReadData),
    .spriteBackgroundHit(bgHit), .spriteSpriteHit(sprHit), .lightPenIn(pen),
    .badLineRequest(badLine), .displayEnable(displayEnable),
    .busStealRequest(busStealRequest), .irqRequest(irqRequest), .rasterLine(rasterLine));
  task automatic giveVerdict;
    if (nFail == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : giveVerdict
  task automatic rd(input logic [15:0] a); host.access(1'b0, a, 8'h00, q); endtask : rd
  task automatic wr(input logic [15:0] a, input logic [7:0] d); host.access(1'b1, a, d, q);
  endtask : wr
  task automatic wait_line(input logic [8:0] l);
    int i;
    for (i = 0; i < 100 && rasterLine !== l; i++) @(posedge clock);
    if (i == 100) begin
      nFail++;
      giveVerdict();
    end
  endtask : wait_line
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd(16'hd013);
    `CHK("unmapped", 8'hff, q)
    rd(16'hd011);
    `CHK("shown at reset", 1'b1, q[4])
  endtask : t_regs
  task automatic t_blank;
    wr(16'hd01a, 8'h05);
    wr(16'hd011, 8'h00);
    `CHK("display", 1'b0, displayEnable)
    `CHK("steal", 1'b0, busStealRequest)
    rd(16'hd01a);
    `CHK("enables kept", 8'hf5, q)
    wr(16'hd011, 8'h10);
    `CHK("steal back", 1'b1, busStealRequest)
    badLine <= 1'b0;
    @(posedge clock);
    `CHK("no fetch", 1'b0, busStealRequest)
    badLine <= 1'b1;
  endtask : t_blank
  task automatic t_raster;
    host.raster_handler(8'h10, 9'h105);
    host.ack(8'h01);
    wait_line(9'h007);
    wait_line(9'h006);
    rd(16'hd019);
    `CHK("top bit compare", 1'b0, q[0])
    host.raster_handler(8'h10, 9'h005);
    wait_line(9'h001);
    host.ack(8'h01);
    rd(16'hd019);
    `CHK("early match", 1'b0, q[0])
    wait_line(9'h005);
    repeat (2) @(posedge clock);
    rd(16'hd019);
    `CHK("match", 1'b1, q[0])
  endtask : t_raster
  task automatic t_events;
    wr(16'hd01a, 8'h00);
    host.ack(8'h0f);
    bgHit <= 1'b1;
    @(posedge clock) bgHit <= 1'b0;
    repeat (4) @(posedge clock);
    rd(16'hd019);
    `CHK("polled", 2'b01, q[2:1])
    `CHK("no request", 1'b0, irqRequest)
    wr(16'hd01a, 8'h06);
    rd(16'hd01a);
    `CHK("request", 1'b1, irqRequest)
    sprHit <= 1'b1;
    @(posedge clock) sprHit <= 1'b0;
    repeat (4) @(posedge clock);
    host.ack(8'h02);
    rd(16'hd019);
    `CHK("selective", 2'b10, q[2:1])
    `CHK("any", 1'b1, q[7])
    host.ack(8'h04);
    `CHK("request off", 1'b0, irqRequest)
    wait_line(9'h001);
    pen <= 1'b0;
    repeat (4) @(posedge clock);
    rd(16'hd019);
    `CHK("pen", 1'b1, q[3])
    host.ack(8'h08);
    pen <= 1'b1;
    repeat (3) @(posedge clock) pen <= 1'b0;
    repeat (4) @(posedge clock);
    rd(16'hd019);
    `CHK("pen once", 1'b0, q[3])
  endtask : t_events
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_blank();
    t_raster();
    t_events();
    giveVerdict();
  end
endmodule : tb_raster_irq_and_blanking
`default_nettype wire
